// *** design/wdrs_pkg.sv ***
// Package: register map, field positions, reset values and event types
package wdrs_pkg;

  // ************************************************************
  // Register map (byte-wide registers, 4-bit address)
  // ************************************************************
  localparam logic [3:0] ADDR_T0_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RELOAD = 4'h1;
  localparam logic [3:0] ADDR_SERVICE = 4'h2;
  localparam logic [3:0] ADDR_CONFIG = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_COUNT = 4'h6;
  localparam logic [3:0] ADDR_T0_PRESET = 4'h7;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int T0_RESTART_BIT = 0;
  localparam int T0_FREEZE_EN_BIT = 5;
  localparam int CFG_CLK_SEL_BIT = 0;
  localparam int CFG_MATCH_EN_BIT = 1;
  localparam int CFG_RUNNING_BIT = 7;
  localparam int EVT_BAD_PATTERN_BIT = 0;
  localparam int EVT_DOUBLE_SVC_BIT = 1;
  localparam int EVT_EXPIRE_BIT = 2;

  // ************************************************************
  // Reset values and constants
  // ************************************************************
  localparam logic [7:0] RELOAD_RST = 8'h0F;
  localparam logic [7:0] SERVICE_PATTERN = 8'h5C;
  localparam logic [7:0] T0_PRESET_RST = 8'h00;
  localparam logic [2:0] EVT_NONE = 3'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic
  {
    WDRS_IDLE = 1'b0,
    WDRS_RUN = 1'b1
  } wdrs_state_t;

  typedef struct packed
  {
    logic expire;
    logic doubleService;
    logic badPattern;
  } wdrs_evt_t;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } wdrs_bus_t;

endpackage

// *** design/wdrs_timer0.sv ***
// Timer 0: divides the timer input clock tick by one plus the preset
`timescale 1ns/10ps

module wdrs_timer0
#(
  parameter int T0_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inTick,
  input wire logic freezeIn,
  input wire logic freezeEnable,
  input wire logic restart,
  input wire logic [T0_W-1:0] preset,
  output logic outTick,
  output logic [T0_W-1:0] count
);

  initial
  begin
    if (T0_W < 1 || T0_W > 8)
      $error("wdrs_timer0: T0_W must lie in 1..8");
  end

  logic frozen;
  logic [T0_W-1:0] count_r;

  // Freeze only counts when the enable bit allows it
  assign frozen = freezeEnable & freezeIn;
  assign outTick = inTick & ~frozen & (count_r == '0);
  assign count = count_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      count_r <= '0;
    else if (restart)
      count_r <= preset;
    else if (inTick && !frozen)
    begin
      if (count_r == '0)
        count_r <= preset;
      else
        count_r <= count_r - 1'b1;
    end
  end

endmodule // wdrs_timer0

// *** design/wdrs_watchdog.sv ***
// Watchdog reload, service match and timer 0 freeze control
`timescale 1ns/10ps

// Overview of operation
// - With freeze enable set, timer 0 halts while freeze input is high.
// - Freeze enable bit is zero after reset.
// - Write-only reload register value reloads the counter on each service.
// - Watchdog idle after reset; first reload write starts it.
// - Later reload writes restart the count from the new value.
// - Reload register holds 0F hex after reset.
// - With match enable, writing 5C hex services and reloads the counter.
// - With match enable, any other written value raises a watchdog error.
// - Two service writes within one watchdog clock raise an error.
// - With match enable clear, service writes are ignored entirely.
// - Config bit selects timer input clock or timer 0 output clock.
module wdrs_watchdog
#(
  parameter int CNT_W = 8,
  parameter int T0_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic timerInTick,
  input wire logic freezeIn,
  output logic watchdogError,
  output logic irq
);

  initial
  begin
    if (CNT_W != 8)
      $error("wdrs_watchdog: CNT_W must be 8 to match the reload byte");
    if (T0_W < 1 || T0_W > 8)
      $error("wdrs_watchdog: T0_W must lie in 1..8");
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] offset);
    hit = (addr == offset);
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  wdrs_pkg::wdrs_bus_t bus;
  wdrs_pkg::wdrs_state_t state_r;
  wdrs_pkg::wdrs_state_t state_nxt;
  wdrs_pkg::wdrs_evt_t events;
  logic freezeEnable_r;
  logic timerRestart;
  logic clockSelect_r;
  logic matchEnable_r;
  logic [7:0] reloadValue_r;
  logic [CNT_W-1:0] counter_r;
  logic [T0_W-1:0] t0Preset_r;
  logic [T0_W-1:0] t0Count;
  logic [2:0] irqStatus_r;
  logic [2:0] irqMask_r;
  logic serviceSeen_r;
  logic watchdogError_r;
  logic [7:0] readData_r;
  logic [7:0] readMux;
  logic timerOutTick;
  logic wdTick;
  logic reloadWrite;
  logic serviceWrite;
  logic serviceOk;
  logic expiring;

  assign bus.addr = regAddr;
  assign bus.wdata = regWriteData;
  assign bus.write = regWrite;
  assign bus.read = regRead;

  assign reloadWrite = bus.write & hit(bus.addr, wdrs_pkg::ADDR_RELOAD);
  // Disabled matching swallows the write without side effect
  assign serviceWrite = bus.write & matchEnable_r &
    hit(bus.addr, wdrs_pkg::ADDR_SERVICE);
  assign timerRestart = bus.write & hit(bus.addr, wdrs_pkg::ADDR_T0_CTRL) &
    bus.wdata[wdrs_pkg::T0_RESTART_BIT];

  // ************************************************************
  // Timer 0 and watchdog clock
  // ************************************************************
  wdrs_timer0
  #(
    .T0_W(T0_W)
  )
  u_timer0
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .inTick(timerInTick),
    .freezeIn(freezeIn),
    .freezeEnable(freezeEnable_r),
    .restart(timerRestart),
    .preset(t0Preset_r),
    .outTick(timerOutTick),
    .count(t0Count)
  );

  assign wdTick = clockSelect_r ? timerInTick : timerOutTick;

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      freezeEnable_r <= 1'b0;
    else if (bus.write && hit(bus.addr, wdrs_pkg::ADDR_T0_CTRL))
      freezeEnable_r <= bus.wdata[wdrs_pkg::T0_FREEZE_EN_BIT];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      clockSelect_r <= 1'b0;
      matchEnable_r <= 1'b0;
    end
    else if (bus.write && hit(bus.addr, wdrs_pkg::ADDR_CONFIG))
    begin
      clockSelect_r <= bus.wdata[wdrs_pkg::CFG_CLK_SEL_BIT];
      matchEnable_r <= bus.wdata[wdrs_pkg::CFG_MATCH_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      t0Preset_r <= wdrs_pkg::T0_PRESET_RST[T0_W-1:0];
    else if (bus.write && hit(bus.addr, wdrs_pkg::ADDR_T0_PRESET))
      t0Preset_r <= bus.wdata[T0_W-1:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      reloadValue_r <= wdrs_pkg::RELOAD_RST;
    else if (reloadWrite)
      reloadValue_r <= bus.wdata;
  end

  // ************************************************************
  // Watchdog run state
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      wdrs_pkg::WDRS_IDLE:
      begin
        if (reloadWrite)
          state_nxt = wdrs_pkg::WDRS_RUN;
      end
      wdrs_pkg::WDRS_RUN:
      begin
        state_nxt = wdrs_pkg::WDRS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_r <= wdrs_pkg::WDRS_IDLE;
    else
      state_r <= state_nxt;
  end

  // ************************************************************
  // Service checking and error events
  // ************************************************************
  // A second write in one watchdog clock is refused, even if it matches;
  // a write on the tick itself opens the next window, so it is not double
  assign serviceOk = serviceWrite & ~(serviceSeen_r & ~wdTick) &
    (bus.wdata == wdrs_pkg::SERVICE_PATTERN);
  assign expiring = (state_r == wdrs_pkg::WDRS_RUN) & wdTick &
    (counter_r == '0) & ~reloadWrite & ~serviceOk;

  always_comb
  begin
    events.badPattern = serviceWrite &
      (bus.wdata != wdrs_pkg::SERVICE_PATTERN);
    events.doubleService = serviceWrite & serviceSeen_r &
      ~wdTick;
    events.expire = expiring;
  end

  // Window of one watchdog clock; a write on the tick opens the next one
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      serviceSeen_r <= 1'b0;
    else if (serviceWrite)
      serviceSeen_r <= 1'b1;
    else if (wdTick)
      serviceSeen_r <= 1'b0;
  end

  // ************************************************************
  // Watchdog counter
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      counter_r <= wdrs_pkg::RELOAD_RST;
    else if (reloadWrite)
      counter_r <= bus.wdata;
    else if (serviceOk && state_r == wdrs_pkg::WDRS_RUN)
      counter_r <= reloadValue_r;
    else if (state_r == wdrs_pkg::WDRS_RUN && wdTick)
    begin
      // Reload after expiry so errors repeat once per full period
      if (counter_r == '0)
        counter_r <= reloadValue_r;
      else
        counter_r <= counter_r - 1'b1;
    end
  end

  // ************************************************************
  // Error output and interrupt
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      watchdogError_r <= 1'b0;
    else
      watchdogError_r <= |events;
  end

  // New events win over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqStatus_r <= wdrs_pkg::EVT_NONE;
    else if (bus.write && hit(bus.addr, wdrs_pkg::ADDR_IRQ_STATUS))
      irqStatus_r <= (irqStatus_r & ~bus.wdata[2:0]) | events;
    else
      irqStatus_r <= irqStatus_r | events;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irqMask_r <= wdrs_pkg::EVT_NONE;
    else if (bus.write && hit(bus.addr, wdrs_pkg::ADDR_IRQ_MASK))
      irqMask_r <= bus.wdata[2:0];
  end

  assign irq = |(irqStatus_r & irqMask_r);
  assign watchdogError = watchdogError_r;

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb
  begin
    readMux = wdrs_pkg::BYTE_ZERO;
    unique case (bus.addr)
      wdrs_pkg::ADDR_T0_CTRL:
        readMux[wdrs_pkg::T0_FREEZE_EN_BIT] = freezeEnable_r;
      wdrs_pkg::ADDR_CONFIG:
      begin
        readMux[wdrs_pkg::CFG_CLK_SEL_BIT] = clockSelect_r;
        readMux[wdrs_pkg::CFG_MATCH_EN_BIT] = matchEnable_r;
        readMux[wdrs_pkg::CFG_RUNNING_BIT] =
          (state_r == wdrs_pkg::WDRS_RUN);
      end
      wdrs_pkg::ADDR_IRQ_STATUS:
        readMux[2:0] = irqStatus_r;
      wdrs_pkg::ADDR_IRQ_MASK:
        readMux[2:0] = irqMask_r;
      wdrs_pkg::ADDR_COUNT:
        readMux = counter_r;
      wdrs_pkg::ADDR_T0_PRESET:
        readMux[T0_W-1:0] = t0Count;
      default:
        readMux = wdrs_pkg::BYTE_ZERO;
    endcase
  end

  // Write-only and unmapped addresses read as zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      readData_r <= wdrs_pkg::BYTE_ZERO;
    else if (bus.read)
      readData_r <= readMux;
    else
      readData_r <= wdrs_pkg::BYTE_ZERO;
  end

  assign regReadData = readData_r;

endmodule // wdrs_watchdog

// *** sim/tb_top.sv ***
// Self-checking bench for the watchdog reload and service block
`timescale 1ns/10ps

module tb_top;
  logic clk_sys;
  logic rst;
  logic [3:0] regAddr;
  logic [7:0] regWriteData;
  logic regWrite;
  logic regRead;
  logic [7:0] regReadData;
  logic timerInTick;
  logic freezeIn;
  logic watchdogError;
  logic irq;
  int miscompares;
  int compares;
  int seed;
  int rlM, cntM, runM, matM, selM, svcM, stM, mskM, frzM, preM, t0M;

  wdrs_watchdog dut
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .regAddr(regAddr),
    .regWriteData(regWriteData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regReadData(regReadData),
    .timerInTick(timerInTick),
    .freezeIn(freezeIn),
    .watchdogError(watchdogError),
    .irq(irq)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [7:0] rdModel(input logic [3:0] a);
    case (a)
      4'h0: return 8'(frzM << 5);
      4'h3: return 8'(runM << 7 | matM << 1 | selM);
      4'h4: return 8'(stM);
      4'h5: return 8'(mskM);
      4'h6: return 8'(cntM);
      4'h7: return 8'(t0M);
      default: return 8'h00;
    endcase
  endfunction

  // ************************************************
  // Bus cycle with optional timer tick, model update
  // ************************************************
  task automatic step(input logic w, input logic [3:0] a,
                      input logic [7:0] d, input logic t);
    logic err;
    logic wdt;
    logic hold;
    err = 1'b0;
    wdt = 1'b0;
    regWrite <= w;
    regAddr <= a;
    regWriteData <= d;
    timerInTick <= t;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    timerInTick <= 1'b0;
    hold = frzM && freezeIn;
    if (t)
    begin
      wdt = selM || (t0M == 0 && !hold);
      if (!hold)
        t0M = t0M == 0 ? preM : t0M - 1;
    end
    if (wdt)
      svcM = 0;
    if (w)
      case (a)
        4'h0: {frzM, t0M} = {int'(d[5]), d[0] ? preM : t0M};
        4'h1: {rlM, cntM, runM, wdt} = {int'(d), int'(d), 1, 1'b0};
        4'h3: {selM, matM} = {int'(d[0]), int'(d[1])};
        4'h4: stM &= ~int'(d);
        4'h5: mskM = d & 8'h07;
        4'h7: preM = d;
        4'h2: if (matM)
        begin
          err = d != 8'h5C || svcM;
          stM |= (d != 8'h5C) | (svcM << 1);
          if (!err && runM)
            {cntM, wdt} = {rlM, 1'b0};
          svcM = 1;
        end
        default: ;
      endcase
    if (wdt && runM)
    begin
      err = err || cntM == 0;
      stM |= (cntM == 0) << 2;
      cntM = cntM == 0 ? rlM : cntM - 1;
    end
    #1;
    check(watchdogError, err);
    check(irq, (stM & mskM) != 0);
  endtask

  task automatic rd(input logic [3:0] a);
    logic [7:0] exp;
    exp = rdModel(a);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    check(regReadData, exp);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    close_out;
  end

  initial
  begin
    int v;
    seed = 32'h5411AE2D;
    {rlM, cntM} = {15, 15};
    {runM, matM, selM, svcM, stM, mskM, frzM, preM, t0M} = '0;
    {regAddr, regWriteData, regWrite, regRead} = '0;
    {timerInTick, freezeIn, rst} = 3'h1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 16; i++) rd(4'(i));
    repeat (3) step(1'b0, 4'h0, 8'h00, 1'b1);
    rd(4'h6);
    step(1'b1, 4'h2, 8'h33, 1'b0);
    step(1'b1, 4'h3, 8'h01, 1'b0);
    v = 2 + $unsigned($random(seed)) % 6;
    step(1'b1, 4'h1, 8'(v), 1'b0);
    step(1'b0, 4'h0, 8'h00, 1'b1);
    step(1'b1, 4'h2, 8'h5C, 1'b0);
    for (int i = 0; i < 16; i++) rd(4'(i));
    step(1'b1, 4'h3, 8'h03, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      step(1'b0, 4'h0, 8'h00, 1'b1);
      step(1'b1, 4'h2, i[0] ? 8'h5C : 8'($random(seed)), 1'b0);
      rd(4'h6);
    end
    step(1'b0, 4'h0, 8'h00, 1'b1);
    step(1'b1, 4'h2, 8'h5C, 1'b0);
    step(1'b1, 4'h2, 8'h5C, 1'b0);
    step(1'b1, 4'h2, 8'h5C, 1'b1);
    v = 3 + $unsigned($random(seed)) % 5;
    step(1'b1, 4'h1, 8'(v), 1'b1);
    rd(4'h6);
    repeat (v + 2)
    begin
      step(1'b0, 4'h0, 8'h00, 1'b1);
      rd(4'h6);
    end
    rd(4'h4);
    step(1'b1, 4'h5, 8'h07, 1'b0);
    step(1'b1, 4'h4, 8'h05, 1'b0);
    step(1'b1, 4'h4, 8'hFF, 1'b0);
    step(1'b1, 4'h3, 8'h02, 1'b0);
    step(1'b1, 4'h7, 8'h02, 1'b0);
    step(1'b1, 4'h0, 8'h21, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      if (i == 10)
        step(1'b1, 4'h0, 8'h00, 1'b0);
      freezeIn <= 1'($random(seed));
      step(1'b0, 4'h0, 8'h00, 1'b1);
      rd(4'h7);
      rd(4'h6);
    end
    for (int i = 0; i < 16; i++) rd(4'(i));
    close_out;
  end
endmodule // tb_top

// *** sim/wdrs_watchdog_assertions.sv ***
// Checker bound to the watchdog top, watching its ports only
`timescale 1ns/10ps

module wdrs_watchdog_chk
#(
  parameter int CNT_W = 8,
  parameter int T0_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic timerInTick,
  input wire logic freezeIn,
  input wire logic watchdogError,
  input wire logic irq
);
  logic matchEn_r;
  logic frz_r;
  logic started_r;
  logic svcWr;
  logic ldWr;
  assign svcWr = regWrite && regAddr == wdrs_pkg::ADDR_SERVICE;
  assign ldWr = regWrite && regAddr == wdrs_pkg::ADDR_RELOAD;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Shadow of the control bits software has written
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      matchEn_r <= 1'b0;
      frz_r <= 1'b0;
      started_r <= 1'b0;
    end
    else if (regWrite)
    begin
      if (regAddr == wdrs_pkg::ADDR_CONFIG)
        matchEn_r <= regWriteData[1];
      if (regAddr == wdrs_pkg::ADDR_T0_CTRL)
        frz_r <= regWriteData[5];
      if (ldWr)
        started_r <= 1'b1;
    end
  end

  property p_woread;
    regRead && (regAddr == 4'h1 || regAddr == 4'h2) |=> regReadData == 8'h00;
  endproperty
  a_woread: assert property (p_woread)
    else $error("write-only register read back nonzero");
  property p_idle;
    regRead && regAddr == 4'h3 && !started_r |=> !regReadData[7];
  endproperty
  a_idle: assert property (p_idle)
    else $error("watchdog running before reload write");
  property p_cntrst;
    regRead && regAddr == 4'h6 && !started_r |=> regReadData == 8'h0F;
  endproperty
  a_cntrst: assert property (p_cntrst)
    else $error("counter left its reset value while idle");
  property p_frzrst;
    regRead && regAddr == 4'h0 |=> regReadData[5] == $past(frz_r);
  endproperty
  a_frzrst: assert property (p_frzrst)
    else $error("freeze enable bit wrong");
  property p_badpat;
    svcWr && matchEn_r && regWriteData != 8'h5C |=> watchdogError;
  endproperty
  a_badpat: assert property (p_badpat)
    else $error("wrong pattern gave no error");
  property p_ignore;
    svcWr && !matchEn_r && !started_r |=> !watchdogError;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("service write not ignored");
  property p_double;
    svcWr && matchEn_r && !timerInTick ##1 svcWr && !timerInTick
      |=> watchdogError;
  endproperty
  a_double: assert property (p_double)
    else $error("double service gave no error");
  property p_restart;
    ldWr ##1 regRead && regAddr == 4'h6 && !timerInTick
      |=> regReadData == $past(regWriteData, 2);
  endproperty
  a_restart: assert property (p_restart)
    else $error("reload write did not restart count");
endmodule // wdrs_watchdog_chk

bind wdrs_watchdog wdrs_watchdog_chk #(.CNT_W(CNT_W), .T0_W(T0_W)) u_chk
(
  .clk_sys(clk_sys),
  .rst(rst),
  .regAddr(regAddr),
  .regWriteData(regWriteData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regReadData(regReadData),
  .timerInTick(timerInTick),
  .freezeIn(freezeIn),
  .watchdogError(watchdogError),
  .irq(irq)
);
